// ---- pkg/spoc_pkg.sv ----
// Package with constants and carrier types for the system power-on control block.
package spoc_pkg;

    // Depth of the input synchroniser chain.
    localparam int unsigned SYNC_STAGES = 2;
    // Reset value of the supply select output (deasserted).
    localparam logic        SELECT_RESET = 1'b0;
    // Length of the supply select pulse used to wake the supply, in ns and cycles.
    localparam int unsigned CLK_PERIOD_NS     = 20;
    localparam int unsigned SELECT_PULSE_NS   = 1000;
    localparam int unsigned SELECT_PULSE_CYC  =
        (SELECT_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 : (SELECT_PULSE_NS / CLK_PERIOD_NS);
    localparam int unsigned PULSE_CNT_W       = 8;

    // Asynchronous supply inputs gathered as one bundle.
    typedef struct packed {
        logic on_button_in;
        logic supply_good_in;
        logic supply_alert_in;
        logic switched_rail_status;
    } spoc_pins_t;

    // Events presented to software.
    typedef struct packed {
        logic power_loss;   // High-priority event.
        logic status_alert; // Low-priority event.
    } spoc_events_t;

    typedef enum logic [2:0] {
        SPOC_OFF  = 3'b001,
        SPOC_WAKE = 3'b010,
        SPOC_ON   = 3'b100
    } spoc_state_t;

endpackage

// ---- hdl/spoc_sync.sv ----
// Two-flip-flop synchroniser for a bundle of asynchronous inputs.
`timescale 1ns/100ps
module spoc_sync import spoc_pkg::*; #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             i_clk,    // System clock.
    input  wire logic             i_arst_n, // Asynchronous reset, active low.
    input  wire logic [WIDTH-1:0] i_async,  // Asynchronous inputs.
    output logic      [WIDTH-1:0] o_sync    // Synchronised outputs.
);

    logic [WIDTH-1:0] meta;

    // Stage one is read only by stage two.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule

// ---- hdl/spoc_top.sv ----
// Reset and system power-on control for the processor.
// How it works
// - Core reset output follows core reset input low, and is also held low by power-on reset.
// - Power-on reset input clears all logic except the core reset synchroniser while held low.
// - On button asserts supply select to request system power on.
// - Supply select never asserts while good-power status is low.
// - Enabled wake interrupt while off also asserts supply select, same gating.
// - Falling good-power while running raises an immediate high-priority event.
// - Supply alert pulse becomes an event prompting a status read.
// - Supply alert is a low-priority event, distinct from power loss.
`timescale 1ns/100ps
module spoc_top import spoc_pkg::*; (
    input  wire logic         i_clk,                  // System clock, 50 MHz.
    input  wire logic         i_arst_n,               // Power-on reset, active low.
    input  wire logic         i_core_reset_n,         // Core reset input, active low.
    input  wire logic         i_on_button_in,         // On button, active high.
    input  wire logic         i_supply_good_in,       // Good-power status from supply.
    input  wire logic         i_supply_alert_in,      // Status-change alert from supply.
    input  wire logic         i_switched_rail_status, // Switched rail status.
    input  wire logic         i_wake_irq,             // Wake interrupt from core logic.
    input  wire logic         i_wake_en,              // Wake interrupt enable.
    input  wire logic         i_sw_power_off,         // Software request to power down.
    input  wire logic         i_event_ack,            // Pulse: clear both event flags.
    output logic              o_core_reset_n,         // Reset to CPU core, active low.
    output logic              o_supply_select_out,    // Chip select to power supply.
    output spoc_events_t      o_events,               // Sticky event flags.
    output logic              o_system_on             // System considered running.
);

    spoc_pins_t  pins_async;
    spoc_pins_t  pins;
    spoc_state_t state;
    spoc_state_t next_state;
    logic        good_d;
    logic        alert_d;
    logic        core_meta;
    logic        core_sync;
    logic [PULSE_CNT_W-1:0] pulse_cnt;
    logic        power_loss_set;
    logic        alert_set;
    logic        wake_req;

    assign pins_async = '{on_button_in:         i_on_button_in,
                          supply_good_in:       i_supply_good_in,
                          supply_alert_in:      i_supply_alert_in,
                          switched_rail_status: i_switched_rail_status};

    spoc_sync #(.WIDTH($bits(spoc_pins_t))) u_sync (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_async  (pins_async),
        .o_sync   (pins)
    );

    // core reset asserts asynchronously, releases synchronously.
    always_ff @(posedge i_clk or negedge i_core_reset_n) begin
        if (!i_core_reset_n) begin
            core_meta <= 1'b0;
            core_sync <= 1'b0;
        end else begin
            core_meta <= 1'b1;
            core_sync <= core_meta;
        end
    end
    // power-on reset also holds the core.
    assign o_core_reset_n = core_sync & i_arst_n;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            good_d  <= 1'b0;
            alert_d <= 1'b0;
        end else begin
            good_d  <= pins.supply_good_in;
            alert_d <= pins.supply_alert_in;
        end
    end

    // wake interrupt only counts when enabled.
    assign wake_req = pins.on_button_in | (i_wake_irq & i_wake_en);

    always_comb begin
        next_state = state;
        unique case (state)
            SPOC_OFF: begin
                if (wake_req && pins.supply_good_in) begin
                    next_state = SPOC_WAKE;
                end
            end
            SPOC_WAKE: begin
                if (!pins.supply_good_in) begin
                    next_state = SPOC_OFF;
                end else if (pulse_cnt == PULSE_CNT_W'(SELECT_PULSE_CYC - 1)) begin
                    next_state = SPOC_ON;
                end
            end
            SPOC_ON: begin
                if (i_sw_power_off) begin
                    next_state = SPOC_OFF;
                end
            end
            default: next_state = SPOC_OFF;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state     <= SPOC_OFF;
            pulse_cnt <= '0;
        end else begin
            state <= next_state;
            if (state == SPOC_WAKE) begin
                pulse_cnt <= pulse_cnt + PULSE_CNT_W'(1);
            end else begin
                pulse_cnt <= '0;
            end
        end
    end

    // select gated by good power; falling edge ends the select pulse.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_supply_select_out <= SELECT_RESET;
        end else begin
            o_supply_select_out <= (next_state == SPOC_WAKE) && pins.supply_good_in;
        end
    end

    assign o_system_on = (state == SPOC_ON);

    assign power_loss_set = good_d && !pins.supply_good_in && (state == SPOC_ON);
    // alert rising edge becomes event; kept separate.
    assign alert_set      = pins.supply_alert_in && !alert_d;

    // Set wins over acknowledge in the same cycle.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_events <= '0;
        end else begin
            o_events.power_loss   <= power_loss_set | (o_events.power_loss & ~i_event_ack);
            o_events.status_alert <= alert_set | (o_events.status_alert & ~i_event_ack);
        end
    end

    // Assertions.
    sequence seq_good_fall;
        good_d && !pins.supply_good_in;
    endsequence

    AST_SELECT_GATED: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_supply_select_out |-> $past(pins.supply_good_in))
        else $error("Supply select asserted without good power.");

    AST_BUTTON_WAKES: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state == SPOC_OFF && pins.on_button_in && pins.supply_good_in) |=> o_supply_select_out)
        else $error("On button did not assert supply select.");

    AST_WAKE_IRQ: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state == SPOC_OFF && i_wake_irq && i_wake_en && pins.supply_good_in)
        |=> o_supply_select_out)
        else $error("Wake interrupt did not assert supply select.");

    AST_NO_WAKE_DISABLED: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state == SPOC_OFF && !pins.on_button_in && !i_wake_en) |=> !o_supply_select_out)
        else $error("Supply select asserted without a request.");

    AST_POWER_LOSS: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state == SPOC_ON) ##0 seq_good_fall |=> o_events.power_loss)
        else $error("Power loss event not raised.");

    AST_ALERT_EVENT: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (pins.supply_alert_in && !alert_d) |=> o_events.status_alert)
        else $error("Supply alert event not raised.");

    AST_ALERT_LOW_PRIO: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (alert_set && !power_loss_set && !o_events.power_loss) |=> !o_events.power_loss)
        else $error("Alert raised the high-priority event.");

    AST_CORE_RESET: assert property (@(posedge i_clk)
        !i_core_reset_n |-> !o_core_reset_n)
        else $error("Core not held in reset.");

    // Attempts start only once the chain has left reset, so its reset zeros are never compared.
    AST_SYNC_DELAY: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $past(i_arst_n) |-> ##2 (pins.supply_good_in == $past(i_supply_good_in, 2)))
        else $error("Good power not delayed by two flip-flops.");

    AST_SELECT_PULSE_ENDS: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $rose(o_supply_select_out) |-> ##[1:60] !o_supply_select_out)
        else $error("Supply select pulse never ended.");

endmodule

// ---- dv/spoc_supply_model.sv ----
// Behavioural model of the external system power supply.
`timescale 1ns/100ps
module spoc_supply_model (
    input  wire logic i_clk,    // System clock.
    input  wire logic i_select, // Supply chip select.
    input  wire logic i_off,    // System powered down.
    input  wire logic i_good,   // Commanded good-power level.
    input  wire logic i_alert,  // Request for an alert pulse.
    output logic      o_good,   // Good-power status.
    output logic      o_alert,  // Status-change alert.
    output logic      o_rail,   // Switched rail status.
    output int        o_cmds    // Commands latched.
);
    logic alert_q;
    // early warning, dropped when the bench says.
    assign o_good = i_good;
    always_ff @(posedge i_clk) alert_q <= i_alert;
    assign o_alert = i_alert & ~alert_q;
    // rail follows select and power down.
    initial begin
        o_rail = 1'b0;
        forever begin
            @(posedge i_select or posedge i_off);
            o_rail <= !i_off;
        end
    end
    initial begin
        o_cmds = 0;
        forever begin
            @(negedge i_select);
            o_cmds <= o_cmds + 1;
        end
    end
endmodule

// ---- dv/tb_system_power_on_control.sv ----
// Self-checking testbench for the system power-on control block.
`timescale 1ns/100ps
module tb_system_power_on_control;
    import spoc_pkg::*;
    logic clk = 0, arst_n = 0, core_n = 1, button = 0, good = 1, alert = 0;
    logic wake = 0, wake_en = 0, off = 0, ack = 0;
    logic         sup_good, sup_alert, rail, core_out, sel, sys_on;
    spoc_events_t ev;
    int           cmds, c, n, error_cnt = 0, comparisons = 0;

    spoc_top DUT (.i_clk(clk), .i_arst_n(arst_n), .i_core_reset_n(core_n),
        .i_on_button_in(button), .i_supply_good_in(sup_good),
        .i_supply_alert_in(sup_alert), .i_switched_rail_status(rail),
        .i_wake_irq(wake), .i_wake_en(wake_en), .i_sw_power_off(off),
        .i_event_ack(ack), .o_core_reset_n(core_out),
        .o_supply_select_out(sel), .o_events(ev), .o_system_on(sys_on));
    spoc_supply_model u_sup (.i_clk(clk), .i_select(sel), .i_off(off),
        .i_good(good), .i_alert(alert), .o_good(sup_good),
        .o_alert(sup_alert), .o_rail(rail), .o_cmds(cmds));

    initial forever #10 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Waits a bounded time for the select output to reach a level.
    task automatic wait_sel(input logic v);
        n = 0;
        while (sel !== v && n < 200) begin
            tick(1);
            n++;
        end
    endtask
    task automatic pulse_off;
        @(posedge clk) off <= 1'b1;
        @(posedge clk) off <= 1'b0;
        tick(3);
    endtask
    task automatic t_refuse;
        @(posedge clk) good <= 1'b0;
        tick(4);
        @(posedge clk) button <= 1'b1;
        tick(60);
        chk("select", 0, sel);
        chk("system on", 0, sys_on);
        @(posedge clk) button <= 1'b0;
        good <= 1'b1;
        tick(4);
        $display("test refuse done");
    endtask
    // Good power lost just after the select pulse starts must end it within four cycles.
    task automatic t_drop;
        @(posedge clk) button <= 1'b1;
        wait_sel(1'b1);
        @(posedge clk) button <= 1'b0;
        good <= 1'b0;
        tick(4);
        chk("select", 0, sel);
        chk("system on", 0, sys_on);
        @(posedge clk) good <= 1'b1;
        tick(4);
        $display("test good drop done");
    endtask
    task automatic t_button;
        c = cmds;
        @(posedge clk) button <= 1'b1;
        wait_sel(1'b1);
        chk("select", 1, sel);
        chk("rise wait", 1, n <= 4);
        @(posedge clk) button <= 1'b0;
        wait_sel(1'b0);
        chk("pulse length", SELECT_PULSE_CYC - 1, n);
        chk("system on", 1, sys_on);
        chk("commands", c + 1, cmds);
        chk("rail", 1, rail);
        $display("test button done");
    endtask
    task automatic t_power_loss;
        @(posedge clk) good <= 1'b0;
        tick(4);
        chk("events", 2, ev);
        chk("select", 0, sel);
        @(posedge clk) ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
        good <= 1'b1;
        tick(4);
        chk("events", 0, ev);
        pulse_off();
        chk("system on", 0, sys_on);
        chk("rail", 0, rail);
        $display("test power loss done");
    endtask
    task automatic t_wake;
        @(posedge clk) wake <= 1'b1;
        tick(10);
        chk("select", 0, sel);
        @(posedge clk) wake_en <= 1'b1;
        wait_sel(1'b1);
        chk("select", 1, sel);
        chk("rise wait", 1, n <= 4);
        @(posedge clk) wake <= 1'b0;
        wake_en <= 1'b0;
        wait_sel(1'b0);
        pulse_off();
        $display("test wake done");
    endtask
    task automatic t_alert;
        @(posedge clk) alert <= 1'b1;
        @(posedge clk) alert <= 1'b0;
        tick(4);
        chk("events", 1, ev);
        @(posedge clk) ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
        tick(1);
        chk("events", 0, ev);
        $display("test alert done");
    endtask
    task automatic t_core;
        @(posedge clk) core_n <= 1'b0;
        tick(1);
        chk("core reset", 0, core_out);
        @(posedge clk) core_n <= 1'b1;
        tick(3);
        chk("core reset", 1, core_out);
        $display("test core reset done");
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        tick(6);
        chk("reset outputs", 0, {sel, ev, sys_on, core_out});
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        tick(4);
        t_refuse();
        t_drop();
        t_button();
        t_power_loss();
        t_wake();
        t_alert();
        t_core();
        close_out();
    end
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        close_out();
    end
endmodule
